// [hdl/timer_one.v]
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "timer_one_defines.vh"
module timer_one (
  // Clock and reset
  input wire clock,
  input wire rst,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External clock pins
  input wire counter_clock_pin,
  input wire osc_input_pin,
  // Special event triggers from the capture/compare units
  input wire special_event_a,
  input wire special_event_b,
  // Pin direction and oscillator control
  output reg [1:0] pin_output_enable,
  output reg osc_inverter_enable,
  // Interrupt request
  output reg overflow_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [5:0] control_reg; // Implemented control bits
  reg [15:0] count_reg; // Count, not reset by rst
  reg overflow_irq_flag_reg; // Latched overflow
  reg overflow_irq_enable_reg; // Overflow enable
  reg [1:0] port_c_direction_reg; // 1 = input
  reg [2:0] prescale_reg; // Ripple prescaler
  reg cnt_pin_meta_reg; // Counter pin, sync stage one
  reg cnt_pin_sync_reg; // Counter pin, sync stage two
  reg osc_pin_meta_reg; // Oscillator pin, sync stage one
  reg osc_pin_sync_reg; // Oscillator pin, sync stage two
  reg ext_prev_reg; // Previous sampled level
  reg ext_armed_reg; // Falling edge seen
  reg aw_held_reg; // Write address latched
  reg w_held_reg; // Write data latched
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire counter_on = control_reg[`BIT_ON];
  wire source_ext = control_reg[`BIT_CS];
  wire osc_en = control_reg[`BIT_OSC_EN];
  wire [1:0] ps_sel = control_reg[`BIT_PS_HI:`BIT_PS_LO];

  // Prescaler tap for a given code
  function prescale_tap;
    input [1:0] sel;
    input [2:0] pre;
    input tick;
    begin
      case (sel)
        2'h0: prescale_tap = tick;
        2'h1: prescale_tap = tick & pre[0];
        2'h2: prescale_tap = tick & (&pre[1:0]);
        default: prescale_tap = tick & (&pre);
      endcase
    end
  endfunction

  // ----------------------------------------
  // External clock path
  // ----------------------------------------
  // Both sync settings use the two-flop path: an unsynchronised path cannot
  // exist on a single clock, so the sync control bit is only stored and read.
  // Each pin settles on its own before the choice, so no raw pin feeds logic.
  // Pin choice depends on oscillator enable
  wire ext_level = osc_en ? osc_pin_sync_reg : cnt_pin_sync_reg;
  always @(posedge clock) begin
    cnt_pin_meta_reg <= counter_clock_pin;
    cnt_pin_sync_reg <= cnt_pin_meta_reg;
    osc_pin_meta_reg <= osc_input_pin;
    osc_pin_sync_reg <= osc_pin_meta_reg;
    ext_prev_reg <= ext_level;
  end
  wire ext_rise = ext_level & ~ext_prev_reg;
  wire ext_fall = ~ext_level & ext_prev_reg;

  // Arm after first falling edge
  always @(posedge clock) begin
    if (rst || !source_ext || !counter_on) begin
      ext_armed_reg <= 1'b0;
    end else if (ext_fall) begin
      ext_armed_reg <= 1'b1;
    end
  end

  // Raw tick before prescaling; internal source ignores sync_n
  wire raw_tick = source_ext ? (ext_rise & ext_armed_reg) : 1'b1;
  wire tick = counter_on & raw_tick;
  wire inc = prescale_tap(ps_sel, prescale_reg, tick);

  // Prescaler counts ticks; cleared when off
  always @(posedge clock) begin
    if (rst || !counter_on) begin
      prescale_reg <= 3'h0;
    end else if (tick) begin
      prescale_reg <= prescale_reg + 3'h1;
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire aw_have = aw_held_reg | s_axi_awvalid;
  wire w_have = w_held_reg | s_axi_wvalid;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_ctrl = wr_lane0 & (wr_addr == `ADDR_CONTROL);
  wire wr_low = wr_lane0 & (wr_addr == `ADDR_COUNT_LOW);
  wire wr_high = wr_lane0 & (wr_addr == `ADDR_COUNT_HIGH);
  wire wr_flags = wr_lane0 & (wr_addr == `ADDR_IRQ_FLAGS);
  wire wr_en = wr_lane0 & (wr_addr == `ADDR_IRQ_ENABLES);
  wire wr_dir = wr_lane0 & (wr_addr == `ADDR_PORT_C_DIR);
  wire wr_known = (wr_addr == `ADDR_CONTROL) || (wr_addr == `ADDR_COUNT_LOW) ||
    (wr_addr == `ADDR_COUNT_HIGH) || (wr_addr == `ADDR_IRQ_FLAGS) ||
    (wr_addr == `ADDR_IRQ_ENABLES) || (wr_addr == `ADDR_PORT_C_DIR);

  // Write channel handshake
  always @(posedge clock) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (wr_fire) begin
        // Complete write, respond
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= ~aw_held_reg;
        s_axi_wready <= ~w_held_reg;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        // Latch whichever half arrives first
        if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
          s_axi_awready <= 1'b1;
        end
        if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
          s_axi_wready <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Read channel, one cycle answer
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CONTROL: s_axi_rdata <= {26'h0, control_reg};
          `ADDR_COUNT_LOW: s_axi_rdata <= {24'h000000, count_reg[7:0]};
          `ADDR_COUNT_HIGH: s_axi_rdata <= {24'h000000, count_reg[15:8]};
          `ADDR_IRQ_FLAGS: s_axi_rdata <= {31'h0, overflow_irq_flag_reg};
          `ADDR_IRQ_ENABLES: s_axi_rdata <= {31'h0, overflow_irq_enable_reg};
          `ADDR_PORT_C_DIR: s_axi_rdata <= {30'h0, port_c_direction_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control and interrupt registers
  // ----------------------------------------
  wire wrap = inc & (count_reg == `COUNT_MAX);

  // Control, enable, direction
  always @(posedge clock) begin
    if (rst) begin
      control_reg <= `CONTROL_RESET;
      overflow_irq_enable_reg <= 1'b0;
      port_c_direction_reg <= 2'h3;
    end else begin
      if (wr_ctrl) begin
        control_reg <= wr_data[5:0];
      end
      if (wr_en) begin
        overflow_irq_enable_reg <= wr_data[`BIT_OVF];
      end
      if (wr_dir) begin
        port_c_direction_reg <= wr_data[1:0];
      end
    end
  end

  // Overflow flag: set beats software clear
  always @(posedge clock) begin
    if (rst) begin
      overflow_irq_flag_reg <= 1'b0;
    end else if (wrap && !wr_low && !wr_high) begin
      overflow_irq_flag_reg <= 1'b1;
    end else if (wr_flags) begin
      overflow_irq_flag_reg <= wr_data[`BIT_OVF];
    end
  end

  // ----------------------------------------
  // Count
  // ----------------------------------------
  // No rst term: count survives resets
  always @(posedge clock) begin
    if (wr_low || wr_high) begin
      if (wr_low) begin
        count_reg[7:0] <= wr_data[7:0];
      end
      if (wr_high) begin
        count_reg[15:8] <= wr_data[7:0];
      end
    end else if (special_event_a || special_event_b) begin
      count_reg <= `COUNT_MIN;
    end else if (inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      overflow_irq <= 1'b0;
      pin_output_enable <= 2'h0;
      osc_inverter_enable <= 1'b0;
    end else begin
      overflow_irq <= overflow_irq_flag_reg & overflow_irq_enable_reg;
      pin_output_enable <= osc_en ? 2'h0 : ~port_c_direction_reg;
      osc_inverter_enable <= osc_en;
    end
  end
endmodule // timer_one

// [pkg/timer_one_defines.vh]
`ifndef TIMER_ONE_DEFINES_VH
`define TIMER_ONE_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL 8'h10
`define ADDR_COUNT_LOW 8'h14
`define ADDR_COUNT_HIGH 8'h18
`define ADDR_IRQ_FLAGS 8'h1C
`define ADDR_IRQ_ENABLES 8'h20
`define ADDR_PORT_C_DIR 8'h24
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_ON 0
`define BIT_CS 1
`define BIT_SYNC_N 2
`define BIT_OSC_EN 3
`define BIT_PS_LO 4
`define BIT_PS_HI 5
`define BIT_OVF 0
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CONTROL_RESET 6'h00
`define CONTROL_MASK 8'h3F
`define COUNT_MAX 16'hFFFF
`define COUNT_MIN 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [tb/ext_clock_source.sv]
`timescale 1ns/1ps
module ext_clock_source (
  // Pins toward the timer
  output logic counter_clock_pin,
  output logic osc_input_pin
);
  // Clock stands still low between bursts
  initial begin
    counter_clock_pin = 1'h0;
    osc_input_pin = 1'h0;
  end
  // Burst of n pulses on the pins in m; 110 ns halves keep phase unrelated to clock
  task automatic burst(input int n, input logic [1:0] m);
    // Start off the clock edge so the first level is not raced
    #3;
    repeat (n) begin
      {osc_input_pin, counter_clock_pin} = m;
      #110;
      {osc_input_pin, counter_clock_pin} = 2'h0;
      #110;
    end
  endtask
endmodule // ext_clock_source

// [tb/timer_one_chk.sv]
`timescale 1ns/1ps
`include "timer_one_defines.vh"
module timer_one_chk (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins and interrupt
  input wire [1:0] pin_output_enable,
  input wire osc_inverter_enable,
  input wire overflow_irq
);
  // One domain, so one clocking and one disable for all
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held too long");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held too long");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
    && !s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_osc_pins: assert property (osc_inverter_enable && $past(osc_inverter_enable) |-> pin_output_enable == 2'h0)
    else $error("oscillator pins driven");
  a_reset_quiet: assert property ($fell(rst) |-> !overflow_irq && !osc_inverter_enable && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule // timer_one_chk

bind timer_one timer_one_chk chk_u (.*);

// [tb/timer_one_test.sv]
`timescale 1ns/1ps
`include "timer_one_defines.vh"
module timer_one_test;
  typedef struct {logic [7:0] lo; logic [7:0] hi; logic [1:0] rsp;} exp_t;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic special_event_a = 1'h0, special_event_b = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq, osc_inverter_enable;
  wire [1:0] s_axi_bresp, s_axi_rresp, pin_output_enable;
  wire [31:0] s_axi_rdata;
  wire counter_clock_pin, osc_input_pin;
  int failures = 0, checks = 0, seed = 38, n;
  logic [31:0] v;
  exp_t rq[$];
  logic [1:0] bq[$];
  always #10 clock = ~clock;
  timer_one dut_u (.*);
  ext_clock_source src_u (.counter_clock_pin(counter_clock_pin), .osc_input_pin(osc_input_pin));
  // Verdict, reached from the end of the run and from any timeout
  task end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Range compare; unknown never matches
  task chk(input logic [31:0] got, lo, hi);
    checks++;
    if ((^got) === 1'hx || got < lo || got > hi) begin
      failures++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task timeout;
    failures++;
    $display("Error at %0t: wait ran out", $time);
    end_sim;
  endtask
  // Bus write; address and data released separately as each is taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = `RESP_OKAY);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    if (n >= 50) timeout;
    // Idle edge so the next request never reassigns a strobe in this step
    @(posedge clock);
  endtask
  // Bus read; expectation queued for the monitor
  task automatic rd(input logic [7:0] a, lo, hi, input logic [1:0] r = `RESP_OKAY);
    rq.push_back('{lo, hi, r});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    if (n >= 50) timeout;
    @(posedge clock);
  endtask
  // Monitor takes the oldest note whenever a response is handed over
  always @(posedge clock) begin
    exp_t e;
    logic [1:0] b;
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      b = bq.pop_front();
      chk(32'(s_axi_bresp), 32'(b), 32'(b));
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk(s_axi_rdata, 32'(e.lo), 32'(e.hi));
      chk(32'(s_axi_rresp), 32'(e.rsp), 32'(e.rsp));
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rd(`ADDR_CONTROL, 8'h00, 8'h00);
    wr(`ADDR_PORT_C_DIR, 8'h01);
    wr(`ADDR_CONTROL, 8'hFE);
    rd(`ADDR_CONTROL, 8'h3E, 8'h3E);
    chk(32'(osc_inverter_enable), 32'h1, 32'h1);
    chk(32'(pin_output_enable), 32'h0, 32'h0);
    wr(`ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clock);
    chk(32'(pin_output_enable), 32'h2, 32'h2);
    wr(8'h3C, 8'h11, `RESP_SLVERR);
    rd(8'h3C, 8'h00, 8'h00, `RESP_SLVERR);
    // Prescale codes: about 83 cycles on, count scales by the ratio;
    // sync bit set to show timer mode ignores it; long idle after stop
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COUNT_HIGH, 8'h00);
      wr(`ADDR_CONTROL, 8'(k * 16 + 5));
      repeat (80) @(posedge clock);
      wr(`ADDR_CONTROL, 8'h00);
      repeat (300) @(posedge clock);
      rd(`ADDR_COUNT_LOW, 8'((80 >> k) - 1), 8'((86 >> k) + 1));
      rd(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
    end
    // Wrap from near the top with the interrupt enabled
    wr(`ADDR_COUNT_LOW, 8'hF0);
    wr(`ADDR_COUNT_HIGH, 8'hFF);
    wr(`ADDR_IRQ_ENABLES, 8'h01);
    wr(`ADDR_CONTROL, 8'h01);
    for (n = 0; n < 40 && overflow_irq !== 1'h1; n++) @(posedge clock);
    if (n >= 40) timeout;
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
    rd(`ADDR_IRQ_FLAGS, 8'h01, 8'h01);
    wr(`ADDR_IRQ_ENABLES, 8'h00);
    repeat (2) @(posedge clock);
    chk(32'(overflow_irq), 32'h0, 32'h0);
    wr(`ADDR_IRQ_FLAGS, 8'h00);
    // External edges: first rising edge after enabling is skipped
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h07);
    src_u.burst(5, 2'h1);
    repeat (8) @(posedge clock);
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_COUNT_LOW, 8'h04, 8'h04);
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h0B);
    src_u.burst(3, 2'h2);
    repeat (8) @(posedge clock);
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_COUNT_LOW, 8'h02, 8'h02);
    // Special events clear a random count without raising the flag
    for (int e = 0; e < 2; e++) begin
      v = $random(seed);
      wr(`ADDR_COUNT_LOW, v[7:0]);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      {special_event_b, special_event_a} <= 2'(1 << e);
      @(posedge clock);
      {special_event_b, special_event_a} <= 2'h0;
      rd(`ADDR_COUNT_LOW, 8'h00, 8'h00);
      rd(`ADDR_COUNT_HIGH, 8'h00, 8'h00);
    end
    rd(`ADDR_IRQ_FLAGS, 8'h00, 8'h00);
    // Byte write while running lands over the increment
    wr(`ADDR_CONTROL, 8'h01);
    wr(`ADDR_COUNT_HIGH, 8'h5A);
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_COUNT_HIGH, 8'h5A, 8'h5A);
    // Write in the same cycle as a special event wins
    special_event_a <= 1'h1;
    fork
      wr(`ADDR_COUNT_LOW, {1'h1, v[30:24]});
      @(posedge clock) special_event_a <= 1'h0;
    join
    rd(`ADDR_COUNT_LOW, {1'h1, v[30:24]}, {1'h1, v[30:24]});
    // Reset with the counter stopped (on bit clear) leaves the count alone
    wr(`ADDR_COUNT_LOW, v[23:16]);
    wr(`ADDR_CONTROL, 8'h3C);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rd(`ADDR_COUNT_LOW, v[23:16], v[23:16]);
    rd(`ADDR_CONTROL, 8'h00, 8'h00);
    repeat (2) @(posedge clock);
    end_sim;
  end
endmodule // timer_one_test
